// ===== hdl/tfc_params.svh
// Purpose: register indices, reset values and frame counts of the transmit framer control block
// Assumes: one 32-bit register word per index, byte address = 4 x index
// Notes: port n copy sits at index + 0x200 x n
//
// Operation
// - spare register bit7..0 maps odd frames 15..1
// - register set repeats per port, stride 0x200
// - framer enable 0 holds port idle, low power
// - init done starts port if framer enabled
// - soft reset bit holds port in reset
// - mode select picks T1 or E1, before init
// - crc6 variant selects standard or Japanese CRC-6
// - F-bits internal or from serial input
// - CRC-6 bits internal or from serial input
// - software signaling inserted only under bit-7 stuffing
// - global stuffing stuffs every all-zero channel
// - B8ZS coding on or off in T1
// - alarm indication sends unframed all ones
// - remote alarm bit sends remote alarm indication
// - slot 0 bits internal or from serial input
// - slot 16 from hardware or software signaling
// - G.802 forces channel block at slot 26
// - spare bit inserted only when its select set
// - bit-7 stuffing enable gates all stuffing
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH

`define TFC_IDX_SA4 9'h169
`define TFC_IDX_SA5 9'h16a
`define TFC_IDX_SA6 9'h16b
`define TFC_IDX_SA7 9'h16c
`define TFC_IDX_SA8 9'h16d
`define TFC_IDX_MODE 9'h180
`define TFC_IDX_CTL1 9'h181
`define TFC_IDX_CTL2 9'h182
`define TFC_IDX_STAT 9'h18f
`define TFC_RST_BYTE 8'h00
`define TFC_MODE_MASK 8'hc3
`define TFC_E1_LAST_BIT 9'd255
`define TFC_T1_LAST_BIT 9'd192
`define TFC_E1_LAST_FRM 5'd15
`define TFC_T1_LAST_FRM 5'd23
`define TFC_G802_BIT 9'd208
`define TFC_TS16_SLOT 5'd16
`define TFC_FAS 7'b0011011
`define TFC_FPS 6'b001011
`define TFC_CRC6_POLY 6'h03

`endif

// ===== hdl/tfc_pkg.sv
// Purpose: types shared by the transmit framer control block
// Assumes: register bytes map bit 7 first onto the struct fields
// Notes: constants live in tfc_params.svh
package tfc_pkg;

  typedef enum logic [2:0] {
    TFC_HALT = 3'b001,
    TFC_WAIT = 3'b010,
    TFC_RUN = 3'b100
  } tfc_state_e;

  typedef struct packed {
    logic framer_enable;
    logic init_done;
    logic [3:0] rsvd;
    logic soft_reset;
    logic line_standard_select;
  } tfc_mode_s;

  typedef struct packed {
    logic crc6_variant_select;
    logic fbit_pass_through;
    logic crc_pass_through;
    logic software_signaling_enable;
    logic global_bit7_stuffing;
    logic b8zs_coding_enable;
    logic alarm_indication_send;
    logic remote_alarm_send;
  } tfc_ctl_t1_s;

  typedef struct packed {
    logic slot0_pass_through;
    logic slot16_source_select;
    logic g802_blocking_enable;
    logic [2:0] other_e1;
    logic alarm_indication_send;
    logic crc4_ctl;
  } tfc_ctl_e1_s;

  typedef struct packed {
    logic positive;
    logic negative;
  } tfc_line_s;

endpackage : tfc_pkg

// ===== hdl/tfc_tx_framer.sv
// Purpose: transmit framer control, four ports, classic Wishbone register slave
// Assumes: one clk_i edge is one line bit time; serial input synchronous to clk_i
// Notes: serial input is delayed one channel so all-zero bytes are seen before they leave
`timescale 1ns/1ps
`default_nettype none
`include "tfc_params.svh"

module tfc_tx_framer #(
  parameter int unsigned PORTS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [PORTS-1:0] transmit_serial_input_i,
  input wire logic [PORTS-1:0] soft_sig_bit_i,
  input wire logic [PORTS-1:0][23:0] per_channel_signaling_enables_i,
  output tfc_pkg::tfc_line_s [PORTS-1:0] line_o,
  output logic [PORTS-1:0] transmit_channel_block_out_o
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  function automatic logic [5:0] crc6_step(input logic [5:0] crc, input logic b);
    logic fb;
    fb = crc[5] ^ b;
    crc6_step = {crc[4:0], 1'b0} ^ (fb ? `TFC_CRC6_POLY : 6'h00);
  endfunction : crc6_step

  logic ack_q;
  logic [31:0] dat_q;
  logic [8:0] rd_sel [PORTS];
  wire [11:0] idx = wb_adr_i[13:2];
  wire [8:0] loc = idx[8:0];
  wire [1:0] port_idx = idx[10:9];
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire port_ok = ~idx[11] & (32'(port_idx) < PORTS);
  wire [31:0] rd_word = port_ok ? {23'h0, rd_sel[port_idx]} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      dat_q <= (req & ~wb_we_i) ? rd_word : 32'h0;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // per-port registers and transmit engine
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [7:0] sa_q [5];
    logic [7:0] snap_q [5];
    tfc_pkg::tfc_mode_s mode_q;
    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    tfc_pkg::tfc_state_e st_q;
    tfc_pkg::tfc_state_e st_d;
    logic e1_q;
    logic [8:0] bit_q;
    logic [4:0] frm_q;
    logic [7:0] sh_q;
    logic zero_q;
    logic [5:0] crc_q;
    logic [5:0] crc_hold_q;
    logic [3:0] fdl_q;
    logic [7:0] os_q;
    logic [2:0] sub_q;
    logic pol_q;
    tfc_pkg::tfc_line_s line_q;
    logic chblk_q;

    tfc_pkg::tfc_ctl_t1_s t1c;
    tfc_pkg::tfc_ctl_e1_s e1c;
    assign t1c = tfc_pkg::tfc_ctl_t1_s'(ctl1_q);
    assign e1c = tfc_pkg::tfc_ctl_e1_s'(ctl1_q);

    wire wr_p = wr & port_ok & (port_idx == 2'(p));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mode_q <= tfc_pkg::tfc_mode_s'(`TFC_RST_BYTE);
        ctl1_q <= `TFC_RST_BYTE;
        ctl2_q <= `TFC_RST_BYTE;
        for (int k = 0; k < 5; k++) sa_q[k] <= `TFC_RST_BYTE;
      end else if (wr_p) begin
        if (loc == `TFC_IDX_MODE) mode_q <= tfc_pkg::tfc_mode_s'(wb_dat_i[7:0] & `TFC_MODE_MASK);
        if (loc == `TFC_IDX_CTL1) ctl1_q <= wb_dat_i[7:0];
        if (loc == `TFC_IDX_CTL2) ctl2_q <= wb_dat_i[7:0];
        for (int k = 0; k < 5; k++) begin
          if (loc == `TFC_IDX_SA4 + 9'(k)) sa_q[k] <= wb_dat_i[7:0];
        end
      end
    end

    assign rd_sel[p] = (loc == `TFC_IDX_MODE) ? {1'b0, mode_q} :
                       (loc == `TFC_IDX_CTL1) ? {1'b0, ctl1_q} :
                       (loc == `TFC_IDX_CTL2) ? {1'b0, ctl2_q} :
                       (loc == `TFC_IDX_SA4) ? {1'b0, sa_q[0]} :
                       (loc == `TFC_IDX_SA5) ? {1'b0, sa_q[1]} :
                       (loc == `TFC_IDX_SA6) ? {1'b0, sa_q[2]} :
                       (loc == `TFC_IDX_SA7) ? {1'b0, sa_q[3]} :
                       (loc == `TFC_IDX_SA8) ? {1'b0, sa_q[4]} :
                       (loc == `TFC_IDX_STAT) ? {frm_q, e1_q, st_q} : 9'h000;

    // ------------------------------------------------------------
    // port state
    // ------------------------------------------------------------
    // soft reset and a cleared init done both park the port; enable is watched live
    assign st_d = (mode_q.soft_reset | ~mode_q.init_done) ? tfc_pkg::TFC_HALT :
                  mode_q.framer_enable ? tfc_pkg::TFC_RUN : tfc_pkg::TFC_WAIT;

    always_ff @(posedge clk_i) begin
      if (rst_i) st_q <= tfc_pkg::TFC_HALT;
      else st_q <= st_d;
    end

    wire run = (st_q == tfc_pkg::TFC_RUN);

    // ------------------------------------------------------------
    // bit position and raw bit
    // ------------------------------------------------------------
    wire in_b = sh_q[7];
    wire [8:0] pb = e1_q ? bit_q : bit_q - 9'd1;
    wire [4:0] slot = pb[7:3];
    wire [2:0] cb = pb[2:0];
    wire last_bit = bit_q == (e1_q ? `TFC_E1_LAST_BIT : `TFC_T1_LAST_BIT);
    wire mf_last = last_bit & (frm_q == (e1_q ? `TFC_E1_LAST_FRM : `TFC_T1_LAST_FRM));

    // e1 slot 0
    wire [2:0] sak = cb - 3'd3;
    wire sa_sel = ctl2_q[3'd4 - sak];
    wire sa_bit = snap_q[sak][frm_q[3:1]];
    wire sa_out = sa_sel ? sa_bit : in_b;
    wire [6:0] fas = `TFC_FAS;
    wire ts0_bit = (cb == 3'd0) ? in_b :
                   ~frm_q[0] ? fas[3'd7 - cb] :
                   (cb == 3'd1) ? 1'b1 :
                   (cb == 3'd2) ? in_b : sa_out;
    wire e1_raw = (slot == 5'd0) ? (e1c.slot0_pass_through ? in_b : ts0_bit) :
                  ((slot == `TFC_TS16_SLOT) & e1c.slot16_source_select) ? soft_sig_bit_i[p] :
                  in_b;

    // t1 esf framing bit
    wire [5:0] fps = `TFC_FPS;
    wire [1:0] fph = frm_q[1:0];
    wire fps_bit = fps[3'd5 - frm_q[4:2]];
    wire crc_bit = crc_hold_q[3'd5 - frm_q[4:2]];
    wire fdl_bit = t1c.remote_alarm_send ? ~fdl_q[3] : 1'b1;
    wire f_from_in = t1c.fbit_pass_through | ((fph == 2'd1) & t1c.crc_pass_through);
    wire t1_f = f_from_in ? in_b :
                (fph == 2'd3) ? fps_bit :
                (fph == 2'd1) ? crc_bit : fdl_bit;

    // t1 payload: stuffing and robbed-bit signaling
    wire ch_en = per_channel_signaling_enables_i[p][slot];
    wire stuff = ctl2_q[0] & zero_q & (t1c.global_bit7_stuffing | ch_en);
    wire sig_ins = ctl2_q[0] & t1c.software_signaling_enable & ch_en;
    wire sig_frm = (frm_q == 5'd5) | (frm_q == 5'd11) | (frm_q == 5'd17) | (frm_q == 5'd23);
    wire t1_raw = (bit_q == 9'd0) ? t1_f :
                  ((cb == 3'd6) & stuff) ? 1'b1 :
                  ((cb == 3'd7) & sig_ins & sig_frm) ? soft_sig_bit_i[p] : in_b;

    wire raw = e1_q ? e1_raw : t1_raw;
    wire crc_in = (bit_q != 9'd0) | t1c.crc6_variant_select;
    wire [5:0] crc_nx = crc_in ? crc6_step(crc_q, raw) : crc_q;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        e1_q <= 1'b0;
        bit_q <= 9'd0;
        frm_q <= 5'd0;
        sh_q <= 8'h00;
        zero_q <= 1'b0;
        crc_q <= 6'h00;
        crc_hold_q <= 6'h00;
        fdl_q <= 4'h0;
        for (int k = 0; k < 5; k++) snap_q[k] <= `TFC_RST_BYTE;
      end else if (!run) begin
        // mode and spare bits are taken fresh at the start of operation
        e1_q <= mode_q.line_standard_select;
        bit_q <= 9'd0;
        frm_q <= 5'd0;
        sh_q <= 8'h00;
        zero_q <= 1'b0;
        crc_q <= 6'h00;
        crc_hold_q <= 6'h00;
        fdl_q <= 4'h0;
        for (int k = 0; k < 5; k++) snap_q[k] <= sa_q[k];
      end else begin
        sh_q <= {sh_q[6:0], transmit_serial_input_i[p]};
        bit_q <= last_bit ? 9'd0 : bit_q + 9'd1;
        if (last_bit) frm_q <= mf_last ? 5'd0 : frm_q + 5'd1;
        if (cb == 3'd0) zero_q <= (sh_q == 8'h00);
        if (!e1_q & (bit_q == 9'd0) & ~fph[0]) fdl_q <= fdl_q + 4'h1;
        crc_q <= mf_last ? 6'h00 : crc_nx;
        if (mf_last) crc_hold_q <= crc_nx;
        if (mf_last) begin
          for (int k = 0; k < 5; k++) snap_q[k] <= sa_q[k];
        end
      end
    end

    // ------------------------------------------------------------
    // line coding
    // ------------------------------------------------------------
    // the coder lags by one byte so an eight-zero run is seen whole before its first bit leaves
    wire ais = ctl1_q[1];
    wire trig = ~e1_q & t1c.b8zs_coding_enable & ~ais & (sub_q == 3'd0) & (os_q == 8'h00);
    wire in_sub = trig | (sub_q != 3'd0);
    wire [2:0] posn = trig ? 3'd0 : sub_q;
    wire is_v = in_sub & ((posn == 3'd3) | (posn == 3'd6));
    wire is_b = in_sub & ((posn == 3'd4) | (posn == 3'd7));
    wire one = ais | (in_sub ? is_b : os_q[7]);
    wire pulse = one | is_v;
    wire ppos = is_v ? pol_q : ~pol_q;

    always_ff @(posedge clk_i) begin
      if (rst_i | !run) begin
        os_q <= 8'h00;
        sub_q <= 3'd0;
        pol_q <= 1'b0;
        line_q <= '0;
        chblk_q <= 1'b0;
      end else begin
        os_q <= {os_q[6:0], raw};
        sub_q <= (in_sub & (posn != 3'd7)) ? posn + 3'd1 : 3'd0;
        if (pulse & ~is_v) pol_q <= ~pol_q;
        line_q <= '{positive: pulse & ppos, negative: pulse & ~ppos};
        chblk_q <= e1_q & e1c.g802_blocking_enable & (bit_q == `TFC_G802_BIT);
      end
    end

    assign line_o[p] = line_q;
    assign transmit_channel_block_out_o[p] = chblk_q;
  end

endmodule : tfc_tx_framer
`default_nettype wire

// ===== testbench/tfc_tx_framer_properties.sv
// Purpose: bus and line timing checks of the transmit framer
// Assumes: bound to every tfc_tx_framer instance
// Notes: line and block pins are watched on port 0 only, except the after-reset quiet check, which covers every port
`timescale 1ns/1ps
`default_nettype none
module tfc_checker #(
  parameter int unsigned PORTS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire tfc_pkg::tfc_line_s [PORTS-1:0] line_o,
  input wire logic [PORTS-1:0] transmit_channel_block_out_o
);
  // ---
  // properties
  // ---
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  reset_quiet_a: assert property ($past(rst_i) |->
    line_o == '0 && transmit_channel_block_out_o == '0)
    else $error("line active after reset");
  line_ami_a: assert property (!(line_o[0].positive && line_o[0].negative))
    else $error("both line polarities at once");
  // block strobe recurs once per frame, so eight quiet cycles never clash
  block_pulse_a: assert property (transmit_channel_block_out_o[0] |=>
    !transmit_channel_block_out_o[0] [*8])
    else $error("block strobe too long");
endmodule : tfc_checker

bind tfc_tx_framer tfc_checker #(.PORTS(PORTS)) u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .line_o(line_o),
  .transmit_channel_block_out_o(transmit_channel_block_out_o)
);
`default_nettype wire

// ===== testbench/tfc_line_partner.sv
// Purpose: far-end line terminal, counts marks and block strobes
// Assumes: one port, marks sampled at each clk_i edge
// Notes: counts are cleared while clear_i is high
`timescale 1ns/1ps
`default_nettype none
module tfc_line_partner (
  input wire logic clk_i,
  input wire logic clear_i,
  input wire tfc_pkg::tfc_line_s line_i,
  input wire logic block_i,
  output var int pulses_o,
  output var int blocks_o,
  output var int bad_o
);
  logic last_pos_q;
  // ---
  // counting
  // ---
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      pulses_o <= 0;
      blocks_o <= 0;
      bad_o <= 0;
    end else begin
      if (line_i.positive || line_i.negative) begin
        pulses_o <= pulses_o + 1;
        last_pos_q <= line_i.positive;
      end
      // a mark of the same polarity as the last one breaks alternation
      if (pulses_o != 0 && line_i.positive && last_pos_q) bad_o <= bad_o + 1;
      if (pulses_o != 0 && line_i.negative && !last_pos_q) bad_o <= bad_o + 1;
      if (block_i) blocks_o <= blocks_o + 1;
    end
  end
endmodule : tfc_line_partner
`default_nettype wire

// ===== testbench/tfc_tx_framer_bench.sv
// Purpose: self-checking bench of the transmit framer control
// Assumes: one register transfer at a time, port 0 line watched
// Notes: a ceiling of 6000 cycles cuts a hang short
`timescale 1ns/1ps
`default_nettype none
module tfc_tx_framer_bench;
  localparam int unsigned PORTS = 4;
  typedef struct packed {
    logic [1:0] port;
    logic [8:0] idx;
    logic [7:0] wdat;
    logic st;
    logic [7:0] mask;
    logic [7:0] exp;
  } tfc_row_s;
  tfc_row_s rows [14] = '{
    '{2'd0, 9'h169, 8'ha5, 1'b0, 8'hff, 8'ha5},
    '{2'd1, 9'h16a, 8'h5a, 1'b0, 8'hff, 8'h5a},
    '{2'd2, 9'h16b, 8'h81, 1'b0, 8'hff, 8'h81},
    '{2'd3, 9'h16c, 8'h7e, 1'b0, 8'hff, 8'h7e},
    '{2'd3, 9'h16d, 8'h01, 1'b0, 8'hff, 8'h01},
    '{2'd1, 9'h181, 8'hff, 1'b0, 8'hff, 8'hff},
    '{2'd2, 9'h180, 8'h3c, 1'b0, 8'hff, 8'h00},
    '{2'd3, 9'h16e, 8'h55, 1'b0, 8'hff, 8'h00},
    '{2'd1, 9'h180, 8'h80, 1'b1, 8'h04, 8'h00},
    '{2'd1, 9'h180, 8'h40, 1'b1, 8'h04, 8'h00},
    '{2'd1, 9'h180, 8'hc0, 1'b1, 8'h0c, 8'h04},
    '{2'd1, 9'h180, 8'hc2, 1'b1, 8'h04, 8'h00},
    '{2'd1, 9'h180, 8'hc1, 1'b1, 8'h0c, 8'h0c},
    '{2'd0, 9'h18f, 8'hff, 1'b1, 8'h07, 8'h01}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [PORTS-1:0] ser_q = '0;
  logic [PORTS-1:0] sig_q = '0;
  logic [PORTS-1:0][23:0] ena_q = '0;
  tfc_pkg::tfc_line_s [PORTS-1:0] line_o;
  logic [PORTS-1:0] chblk_o;
  logic clear_q = 1'b0;
  logic [7:0] q;
  int pulses;
  int blocks;
  int bad;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2.5 clk_i = ~clk_i;
  tfc_tx_framer #(.PORTS(PORTS)) dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .transmit_serial_input_i(ser_q),
    .soft_sig_bit_i(sig_q),
    .per_channel_signaling_enables_i(ena_q),
    .line_o(line_o),
    .transmit_channel_block_out_o(chblk_o)
  );
  tfc_line_partner far (
    .clk_i(clk_i),
    .clear_i(clear_q),
    .line_i(line_o[0]),
    .block_i(chblk_o[0]),
    .pulses_o(pulses),
    .blocks_o(blocks),
    .bad_o(bad)
  );
  // ---
  // tasks
  // ---
  task automatic summarize();
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // index = port x 0x200 + register, byte address = 4 x index
  task automatic wb_xfer(input logic w, input logic [1:0] p, input logic [8:0] i,
                         input logic [7:0] d, output logic [7:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {1'b0, p, i, 2'b00};
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  task automatic window(input int n);
    clear_q <= 1'b1;
    @(posedge clk_i);
    clear_q <= 1'b0;
    repeat (n + 1) @(posedge clk_i);
  endtask : window
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      summarize();
    end
  end
  // ---
  // sequence
  // ---
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[k]) begin
      wb_xfer(1'b1, rows[k].port, rows[k].idx, rows[k].wdat, q);
      wb_xfer(1'b0, rows[k].port, rows[k].st ? 9'h18f : rows[k].idx, 8'h00, q);
      check("register row", {24'h0, rows[k].exp}, {24'h0, q & rows[k].mask});
    end
    wb_xfer(1'b0, 2'd0, 9'h16a, 8'h00, q);
    check("other port copy", 32'h0, {24'h0, q});
    // a write with the low byte lane off must leave the register alone
    wb_sel_i <= 4'h0;
    wb_xfer(1'b1, 2'd2, 9'h16b, 8'h3c, q);
    wb_sel_i <= 4'h1;
    wb_xfer(1'b0, 2'd2, 9'h16b, 8'h00, q);
    check("lane off write", 32'h81, {24'h0, q});
    wb_xfer(1'b1, 2'd0, 9'h181, 8'h02, q);
    wb_xfer(1'b1, 2'd0, 9'h180, 8'h40, q);
    window(64);
    check("disabled pulses", 32'h0, pulses);
    wb_xfer(1'b1, 2'd0, 9'h180, 8'h80, q);
    wb_xfer(1'b1, 2'd0, 9'h180, 8'hc0, q);
    repeat (20) @(posedge clk_i);
    window(64);
    check("alarm pulses", 32'd64, pulses);
    check("alarm alternation", 32'h0, bad);
    wb_xfer(1'b1, 2'd0, 9'h180, 8'hc2, q);
    repeat (20) @(posedge clk_i);
    window(64);
    check("soft reset pulses", 32'h0, pulses);
    wb_xfer(1'b1, 2'd0, 9'h180, 8'h00, q);
    wb_xfer(1'b1, 2'd0, 9'h181, 8'h20, q);
    wb_xfer(1'b1, 2'd0, 9'h180, 8'h81, q);
    wb_xfer(1'b1, 2'd0, 9'h180, 8'hc1, q);
    window(512);
    check("block strobes", 32'd2, blocks);
    summarize();
  end
endmodule : tfc_tx_framer_bench
`default_nettype wire
